// [src/rcl_pkg.sv]
// Package for the resolution control latches: field positions, widths and
// reset values. Assumes a single 20 MHz clock domain around it.
package rcl_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int SEL_BIT = 7;
  localparam int BW_W = 3;
  localparam int BW_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int GAIN_LSB = 0;
  localparam int BAND_W = 4;
  localparam int BAND_LSB = 3;
  localparam int NUM_BANDS = 16;
  localparam int NUM_FILTERS = 8;
  localparam int BOOST_FIRST = 4;
  localparam int BOOST_LAST = 10;
  localparam logic [ADDR_W-1:0] CTRL_ADDR_RST = 6'h00;
  localparam logic [BW_W-1:0] BW_RST = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_RST = 3'h0;
  localparam logic [BAND_W-1:0] BAND_RST = 4'h0;
  localparam logic [GAIN_W-1:0] ATTEN_RST = 3'h7;
  localparam logic BOOST_N_RST = 1'h1;
  localparam logic [NUM_BANDS-1:0] BOOST_LINKS_RST = 16'h07f0;
endpackage : rcl_pkg

// [src/rcl_onehot_low.sv]
// Active-low one-of-N decoder, combinational.
// Assumes the index is driven from flip-flops in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module rcl_onehot_low #(
  parameter int IDX_W = 3,
  parameter int N = 8
) (
  // Binary index
  input wire logic [IDX_W-1:0] idx_i,
  // Decoded lines, selected one low
  output logic [N-1:0] sel_n_o
);
  always_comb
  begin
    sel_n_o = '1;
    sel_n_o[idx_i] = 1'b0;
  end
endmodule : rcl_onehot_low
`default_nettype wire

// [src/rcl_resolution_control_latches.sv]
// Write-only control decode for the variable resolution section: two
// latches loaded from the microprocessor bus, gain line inversion, band
// decode and gain boost.
// Assumes bus inputs are synchronous to mclk_i and that the board sets
// the answering address and the boost links as static levels.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Write taken only on address match with data valid; else latches hold.
// - Data bit 7 chooses bandwidth latch (0) or gain/band latch (1).
// - Bandwidth latch takes data bits 0 to 2 only.
// - Bandwidth code goes out as binary to both filter-select units.
// - Second latch takes bits 0-2 as gain steps, 3-6 as band.
// - Each stored gain bit is inverted before driving its attenuator line.
// - Bit 0 drives 10 dB unit; bits 1, 2 the 20 dB unit's pads.
// - Band bits feed one-of-N decoder; selected band output goes low.
// - Bands 4 to 10 with fitted link also assert gain boost, low.
// - Each filter decoder drives only the chosen filter's select low.
module rcl_resolution_control_latches
  import rcl_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Microprocessor bus
  input wire logic [rcl_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic bus_data_valid_i,
  input wire logic [rcl_pkg::DATA_W-1:0] bus_data_i,
  // Configuration
  input wire logic [rcl_pkg::ADDR_W-1:0] ctrl_addr_i,
  input wire logic [rcl_pkg::NUM_BANDS-1:0] boost_link_fitted_i,
  // Filter-select units
  output logic [rcl_pkg::BW_W-1:0] bw_code_1st_o,
  output logic [rcl_pkg::BW_W-1:0] bw_code_2nd_o,
  output logic [rcl_pkg::NUM_FILTERS-1:0] filter_sel_1st_n_o,
  output logic [rcl_pkg::NUM_FILTERS-1:0] filter_sel_2nd_n_o,
  // Gain step attenuator controls
  output logic atten_10db_unit_o,
  output logic atten_20u_10db_o,
  output logic atten_20u_20db_o,
  // Band leveling
  output logic [rcl_pkg::BAND_W-1:0] band_code_o,
  output logic [rcl_pkg::NUM_BANDS-1:0] band_sel_n_o,
  output logic gain_boost_line_n_o
);
  import rcl_pkg::*;

  // Latch state, next values and write strobes.
  logic [BW_W-1:0] bw_q;
  logic [BW_W-1:0] bw_d;
  logic [GAIN_W-1:0] gain_q;
  logic [GAIN_W-1:0] gain_d;
  logic [BAND_W-1:0] band_q;
  logic [BAND_W-1:0] band_d;
  logic atten0_q;
  logic atten0_d;
  logic atten1_q;
  logic atten1_d;
  logic atten2_q;
  logic atten2_d;
  logic boost_n_q;
  logic boost_n_d;
  logic hit;
  logic wr_bw;
  logic wr_gb;
  logic [NUM_BANDS-1:0] band_dec_n;
  logic [NUM_BANDS-1:0] boost_req;

  // Data bit 7 acts as one more address line: it picks the latch and is
  // never stored, so software cannot learn afterwards which latch it hit.
  assign hit = bus_data_valid_i && (bus_addr_i == ctrl_addr_i);
  assign wr_bw = hit && !bus_data_i[SEL_BIT];
  assign wr_gb = hit && bus_data_i[SEL_BIT];

  // Bandwidth latch. Bits 3 to 6 of a bandwidth write never reach it, so
  // stray band bits left on the bus cannot disturb the filter choice.
  // A write to the other latch leaves it alone.
  always_comb
  begin
    bw_d = bw_q;
    if (wr_bw)
    begin
      bw_d = bus_data_i[BW_LSB +: BW_W];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      bw_q <= BW_RST;
    end
    else
    begin
      bw_q <= bw_d;
    end
  end

  // Gain and band latch: one write sets both fields together.
  always_comb
  begin
    gain_d = gain_q;
    band_d = band_q;
    if (wr_gb)
    begin
      gain_d = bus_data_i[GAIN_LSB +: GAIN_W];
      band_d = bus_data_i[BAND_LSB +: BAND_W];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      gain_q <= GAIN_RST;
      band_q <= BAND_RST;
    end
    else
    begin
      gain_q <= gain_d;
      band_q <= band_d;
    end
  end

  // The code stays binary on the wires; each unit decodes it locally,
  // which keeps the wiring between units narrow.
  assign bw_code_1st_o = bw_q;
  assign bw_code_2nd_o = bw_q;

  // Both filter-select units decode the same stored code, so they agree.
  rcl_onehot_low #(
    .IDX_W(BW_W),
    .N(NUM_FILTERS)
  ) u_filt_1st (
    .idx_i(bw_q),
    .sel_n_o(filter_sel_1st_n_o)
  );

  rcl_onehot_low #(
    .IDX_W(BW_W),
    .N(NUM_FILTERS)
  ) u_filt_2nd (
    .idx_i(bw_q),
    .sel_n_o(filter_sel_2nd_n_o)
  );

  // Band 0 is an unused code, yet its decoder line goes low after reset;
  // the leveling side must treat that line as doing nothing.
  rcl_onehot_low #(
    .IDX_W(BAND_W),
    .N(NUM_BANDS)
  ) u_band (
    .idx_i(band_q),
    .sel_n_o(band_dec_n)
  );

  // Attenuator drives are registered so they change cleanly, one clock
  // after the latch itself.
  always_comb
  begin
    atten0_d = ~gain_q[0];
    atten1_d = ~gain_q[1];
    atten2_d = ~gain_q[2];
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      atten0_q <= ATTEN_RST[0];
      atten1_q <= ATTEN_RST[1];
      atten2_q <= ATTEN_RST[2];
    end
    else
    begin
      atten0_q <= atten0_d;
      atten1_q <= atten1_d;
      atten2_q <= atten2_d;
    end
  end

  // Each band in the boost range pulls the shared line low only when its
  // link is fitted. A link fitted outside that range has no effect, so a
  // wrong calibration strap cannot boost the low bands.
  always_comb
  begin
    boost_req = '0;
    for (int b = BOOST_FIRST; b <= BOOST_LAST; b++)
    begin
      boost_req[b] = boost_link_fitted_i[b] && !band_dec_n[b];
    end
  end

  // The boost line is registered as well, which puts it one clock behind
  // the band code; it is not valid in the cycle after the write.
  always_comb
  begin
    boost_n_d = ~|boost_req;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      boost_n_q <= BOOST_N_RST;
    end
    else
    begin
      boost_n_q <= boost_n_d;
    end
  end

  // Every output below is a flip-flop or a decoder fed only by
  // flip-flops, so bus activity alone never disturbs it.
  assign atten_10db_unit_o = atten0_q;
  assign atten_20u_10db_o = atten1_q;
  assign atten_20u_20db_o = atten2_q;
  assign gain_boost_line_n_o = boost_n_q;
  assign band_code_o = band_q;
  assign band_sel_n_o = band_dec_n;
endmodule : rcl_resolution_control_latches
`default_nettype wire

// [bench/rcl_host_model.sv]
// Host bus model: one write per call; a released bus shows inverted data.
// Assumes the block samples the bus on rising edges of clk_i.
`timescale 1ns/1ns
`default_nettype none
module rcl_host_model (
  input wire logic clk_i,
  output logic [5:0] a_o = 6'h00,
  output logic v_o = 1'b0,
  output logic [7:0] d_o = 8'h00
);
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk_i);
    {a_o, d_o, v_o} <= {a, d, 1'b1};
    @(posedge clk_i);
    {a_o, d_o, v_o} <= {~a, ~d, 1'b0};
  endtask : wr
endmodule : rcl_host_model
`default_nettype wire

// [bench/rcl_props.sv]
// Port assertions for the latches; bus moves just after mclk_i edges.
// Bound into the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module rcl_props (
  input wire logic mclk_i, sys_rst_i, bus_data_valid_i,
  input wire logic [5:0] bus_addr_i, ctrl_addr_i,
  input wire logic [7:0] bus_data_i,
  input wire logic [15:0] boost_link_fitted_i, band_sel_n_o,
  input wire logic [2:0] bw_code_1st_o, bw_code_2nd_o,
  input wire logic [3:0] band_code_o,
  input wire logic atten_10db_unit_o, gain_boost_line_n_o,
  input wire logic atten_20u_10db_o, atten_20u_20db_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic hit = bus_data_valid_i && bus_addr_i == ctrl_addr_i;
  wire logic wb = hit && !bus_data_i[7];
  wire logic wg = hit && bus_data_i[7];
  wire logic bs = band_code_o inside {[4:10]} &&
    boost_link_fitted_i[band_code_o];
  property p_bw; wb |=> bw_code_1st_o == $past(bus_data_i[2:0]); endproperty
  a_bw: assert property (p_bw) else $error("bw");
  property p_bwh; !wb |=> $stable(bw_code_1st_o); endproperty
  a_bwh: assert property (p_bwh) else $error("bw hold");
  property p_two; bw_code_2nd_o == bw_code_1st_o; endproperty
  a_two: assert property (p_two) else $error("bw pair");
  property p_bd; wg |=> band_code_o == $past(bus_data_i[6:3]); endproperty
  a_bd: assert property (p_bd) else $error("band");
  property p_bdh; !wg |=> $stable(band_code_o); endproperty
  a_bdh: assert property (p_bdh) else $error("band hold");
  property p_att; wg |=> ##1 {atten_20u_20db_o, atten_20u_10db_o,
    atten_10db_unit_o} == ~$past(bus_data_i[2:0], 2); endproperty
  a_att: assert property (p_att) else $error("atten");
  property p_sel; band_sel_n_o == ~(16'h1 << band_code_o); endproperty
  a_sel: assert property (p_sel) else $error("band sel");
  // Boost is registered from the band, so it is judged once the band settles.
  property p_bst; $stable(band_code_o) |-> gain_boost_line_n_o != bs;
  endproperty
  a_bst: assert property (p_bst) else $error("boost");
  c_bw: cover property (wb);
  c_bd: cover property (wg);
  c_bst: cover property (!gain_boost_line_n_o);
endmodule : rcl_props
bind rcl_resolution_control_latches rcl_props u_props (.mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i), .bus_data_valid_i(bus_data_valid_i),
  .bus_addr_i(bus_addr_i), .ctrl_addr_i(ctrl_addr_i),
  .bus_data_i(bus_data_i), .boost_link_fitted_i(boost_link_fitted_i),
  .band_sel_n_o(band_sel_n_o), .bw_code_1st_o(bw_code_1st_o),
  .bw_code_2nd_o(bw_code_2nd_o), .band_code_o(band_code_o),
  .atten_10db_unit_o(atten_10db_unit_o),
  .atten_20u_10db_o(atten_20u_10db_o),
  .atten_20u_20db_o(atten_20u_20db_o),
  .gain_boost_line_n_o(gain_boost_line_n_o));
`default_nettype wire

// [bench/test_resolution_control_latches.sv]
// Self-checking bench for the latches; the host model drives the bus.
// Assumes the block answers within two clock edges of a write.
`timescale 1ns/1ns
`default_nettype none
module test_resolution_control_latches;
  localparam logic [15:0] L = 16'h05f4;
  localparam logic [11:0] G = {3'h7, 3'h5, 3'h4, 3'h1};
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, bus_data_valid_i;
  logic atten_10db_unit_o, atten_20u_10db_o, atten_20u_20db_o;
  logic gain_boost_line_n_o;
  logic [5:0] bus_addr_i, ctrl_addr_i = 6'h2a;
  logic [7:0] bus_data_i, filter_sel_1st_n_o, filter_sel_2nd_n_o;
  logic [2:0] bw_code_1st_o, bw_code_2nd_o;
  logic [3:0] band_code_o;
  logic [15:0] band_sel_n_o, boost_link_fitted_i = L;
  int fail_count = 0, checked = 0, cyc = 0;
  always #25 mclk_i = ~mclk_i;
  rcl_host_model u_host (.clk_i(mclk_i), .a_o(bus_addr_i),
    .v_o(bus_data_valid_i), .d_o(bus_data_i));
  rcl_resolution_control_latches u_dut (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .bus_addr_i(bus_addr_i),
    .bus_data_valid_i(bus_data_valid_i), .bus_data_i(bus_data_i),
    .ctrl_addr_i(ctrl_addr_i), .boost_link_fitted_i(boost_link_fitted_i),
    .bw_code_1st_o(bw_code_1st_o), .bw_code_2nd_o(bw_code_2nd_o),
    .filter_sel_1st_n_o(filter_sel_1st_n_o),
    .filter_sel_2nd_n_o(filter_sel_2nd_n_o),
    .atten_10db_unit_o(atten_10db_unit_o),
    .atten_20u_10db_o(atten_20u_10db_o),
    .atten_20u_20db_o(atten_20u_20db_o), .band_code_o(band_code_o),
    .band_sel_n_o(band_sel_n_o), .gain_boost_line_n_o(gain_boost_line_n_o));
  task automatic chk(string n, logic [19:0] e, v);
    checked++;
    if (v !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, v);
    end
  endtask : chk
  task automatic summarize();
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // Two edges: the latch answers after one, the inverters after two.
  task automatic wt(logic [5:0] a, logic [7:0] d);
    u_host.wr(a, d);
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : wt
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 500)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      wt(6'h2a, {5'h0f, k[2:0]});
      chk("bw", 20'({2{k[2:0]}}),
        20'({bw_code_1st_o, bw_code_2nd_o}));
      chk("fsel", 20'({2{8'(~(8'h1 << k))}}),
        20'({filter_sel_1st_n_o, filter_sel_2nd_n_o}));
    end
    $display("bandwidth test done");
    for (int b = 1; b < 16; b++)
    begin
      wt(6'h2a, {1'b1, b[3:0], G[b % 4 * 3 +: 3]});
      chk("band", {b[3:0], ~(16'h1 << b)}, {band_code_o,
        band_sel_n_o});
      chk("gain", 20'({!(b inside {[4:10]} && L[b]),
        ~G[b % 4 * 3 +: 3], 3'h7}), 20'({gain_boost_line_n_o,
        atten_20u_20db_o, atten_20u_10db_o, atten_10db_unit_o,
        bw_code_1st_o}));
    end
    // The release after this write shows the matching address with valid
    // low and a bandwidth pattern, so that cycle must be ignored as well.
    wt(6'h15, 8'h82);
    chk("refused", 20'({4'hf, 3'h7}),
      20'({band_code_o, bw_code_1st_o}));
    $display("gain, band and refusal tests done");
    summarize();
  end
endmodule : test_resolution_control_latches
`default_nettype wire
